// ===== sgrc_pkg.sv
// Purpose: shared constants for the sleep, clock gating and reset control block
// Assumes: 8-bit register port, 200 MHz system clock
// Notes: offsets are register indices on the plain register port
`default_nettype none
package sgrc_pkg;
	// register offsets
	localparam logic [7:0] SLEEP_CTRL_OFS = 8'h33;
	localparam logic [7:0] GATE_OFS = 8'h34;
	localparam logic [7:0] MCU_CTRL_OFS = 8'h35;
	localparam logic [7:0] CMP_CTRL_OFS = 8'h36;
	localparam logic [7:0] STATUS_OFS = 8'h37;
	// reset values
	localparam logic [7:0] SLEEP_CTRL_RST = 8'h00;
	localparam logic [4:0] GATE_RST = 5'h00;
	// field positions
	localparam int SLEEP_EN_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int LCD_BIT = 4;
	localparam int TIMER1_BIT = 3;
	localparam int SPI_BIT = 2;
	localparam int USART_BIT = 1;
	localparam int ADC_BIT = 0;
	localparam int JTAG_DIS_BIT = 7;
	localparam int CMP_BG_BIT = 6;
	// sleep mode codes
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_ADC_NR = 3'h1;
	localparam logic [2:0] MODE_PDOWN = 3'h2;
	localparam logic [2:0] MODE_PSAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	// standby wake latency in clock cycles
	localparam logic [2:0] STANDBY_WAKE_CYC = 3'h6;
	// delay counter lengths in cycles, indexed by fuse code
	localparam int DELAY_W = 16;
	localparam logic [15:0] DELAY_SHORT = 16'h0010;
	localparam logic [15:0] DELAY_MID = 16'h0100;
	localparam logic [15:0] DELAY_LONG = 16'h1000;
	localparam logic [15:0] DELAY_MIN = 16'h0001;
endpackage
`default_nettype wire

// ===== sgrc_sync.sv
// Purpose: two flip-flop synchroniser for one asynchronous level
// Assumes: destination clock with clock enable
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module sgrc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// data
	input wire logic din,
	output logic dout
);
	logic stage1; // metastability catcher

	// two stage shift
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= RST_VAL;
			dout <= RST_VAL;
		end else if (ce) begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule
`default_nettype wire

// ===== sgrc_ctrl.sv
// Purpose: sleep mode decode, peripheral clock gating, reset combining and stretching
// Assumes: reset sources arrive asynchronous except the watchdog pulse; core on the same clock drives the register port
// Notes: internal reset is held while any source is active and for the fuse delay after
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module sgrc_ctrl
	import sgrc_pkg::*;
(
	// clock, enable and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// core sleep handshake
	input wire logic sleepInstr,
	input wire logic extCrystalSel,
	output logic sleeping,
	output logic [2:0] activeMode,
	output logic coreRun,
	// wake sources
	input wire logic wakeIntAny,
	input wire logic wakeSerialStart,
	input wire logic wakeExtLevel0,
	input wire logic wakePinChange,
	// reset sources, asynchronous except the watchdog pulse
	input wire logic powerLow,
	input wire logic resetPin_n,
	input wire logic watchdogPulse,
	input wire logic brownoutLow,
	input wire logic jtagResetReg,
	// fuses
	input wire logic [1:0] startup_time_fuses,
	input wire logic [3:0] clock_select_fuses,
	input wire logic [1:0] brownout_level_fuses,
	input wire logic jtagFuseProg,
	// peripheral and analog controls
	input wire logic adcEnabled,
	input wire logic tapShifting,
	input wire logic tdoData,
	output logic lcd_gate,
	output logic timer1_gate,
	output logic spi_gate,
	output logic usart_gate,
	output logic adc_gate,
	output logic cmpMuxAllowed,
	output logic bandgapEn,
	output logic jtagEnabled,
	output logic tdoOut,
	output logic tdoOe,
	output logic ioPortReset,
	output logic internalReset
);
	typedef enum {ST_RUN, ST_SLEEP, ST_WAKE} sgrc_state_t; // sleep sequencer states

	// synchronised reset sources
	logic porSync;
	logic pinLowSync;
	logic bodSync;
	logic jtagSync;
	// registers
	logic [2:0] sleep_mode_select;
	logic sleep_enable;
	logic [4:0] clock_gate_reg;
	logic jtag_disable_bit;
	logic comparator_bandgap_select;
	// reset stretch
	logic [15:0] delayCnt;
	logic [15:0] delayLen;
	logic brownoutEnabled;
	logic anySource; // level sources combined, asynchronous
	logic srcActive; // synchronised and watchdog combined
	// sleep sequencer
	sgrc_state_t state;
	sgrc_state_t next_state;
	logic [2:0] wakeCnt;
	logic wakeEvent;
	logic modeValid;

	// level sources combine for the asynchronous port reset
	assign brownoutEnabled = (brownout_level_fuses != 2'h3);
	assign anySource = powerLow | ~resetPin_n | (brownoutLow & brownoutEnabled) | jtagResetReg;
	// ports go to reset state with no clock needed
	assign ioPortReset = anySource | watchdogPulse;

	// each level source presets its synchroniser at once and the release is retimed by two edges,
	// so a source shorter than the synchroniser latency still reloads the stretch counter
	sgrc_sync #(.RST_VAL(1'b1)) syncPor (.clk(clk), .rst_n(rst_n & ~powerLow), .ce(clkEn), .din(1'b0),
		.dout(porSync));
	sgrc_sync #(.RST_VAL(1'b1)) syncPin (.clk(clk), .rst_n(rst_n & resetPin_n), .ce(clkEn), .din(1'b0),
		.dout(pinLowSync));
	sgrc_sync #(.RST_VAL(1'b1)) syncBod (.clk(clk), .rst_n(rst_n & ~(brownoutLow & brownoutEnabled)),
		.ce(clkEn), .din(1'b0), .dout(bodSync));
	sgrc_sync #(.RST_VAL(1'b1)) syncJtag (.clk(clk), .rst_n(rst_n & ~jtagResetReg), .ce(clkEn), .din(1'b0),
		.dout(jtagSync));

	// watchdog pulse is one system cycle and on this clock, so it is used directly
	assign srcActive = porSync | pinLowSync | bodSync | jtagSync | watchdogPulse;

	// delay length chosen by the start-up and clock select fuses
	always_comb begin
		case (startup_time_fuses)
			2'h0: delayLen = DELAY_MIN;
			2'h1: delayLen = DELAY_SHORT;
			2'h2: delayLen = DELAY_MID;
			default: delayLen = DELAY_LONG;
		endcase
		// slow clock options get the longest stretch
		if (clock_select_fuses[3]) begin
			delayLen = DELAY_LONG;
		end
	end

	// stretch counter reloads while any source is active, counts down after
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			delayCnt <= DELAY_LONG;
		end else if (clkEn) begin
			if (srcActive) begin
				delayCnt <= delayLen;
			end else if (delayCnt != 16'h0000) begin
				delayCnt <= delayCnt - 16'h0001;
			end
		end
	end

	// internal reset asserts at once on a source, releases after the count
	assign internalReset = anySource | srcActive | (delayCnt != 16'h0000);
	assign coreRun = ~internalReset & (state != ST_SLEEP) & (state != ST_WAKE);

	// sleep control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_mode_select <= SLEEP_CTRL_RST[3:1];
			sleep_enable <= SLEEP_CTRL_RST[0];
		end else if (clkEn) begin
			if (internalReset) begin
				sleep_mode_select <= SLEEP_CTRL_RST[3:1];
				sleep_enable <= SLEEP_CTRL_RST[0];
			end else if (regWr && regAddr == SLEEP_CTRL_OFS) begin
				sleep_mode_select <= regWdata[MODE_LSB +: 3];
				sleep_enable <= regWdata[SLEEP_EN_BIT];
			end
		end
	end

	// clock gate register, five implemented bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_gate_reg <= GATE_RST;
		end else if (clkEn) begin
			if (internalReset) begin
				clock_gate_reg <= GATE_RST;
			end else if (regWr && regAddr == GATE_OFS) begin
				clock_gate_reg <= regWdata[4:0];
			end
		end
	end

	// mcu control and comparator control bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			jtag_disable_bit <= 1'b0;
			comparator_bandgap_select <= 1'b0;
		end else if (clkEn) begin
			if (internalReset) begin
				jtag_disable_bit <= 1'b0;
				comparator_bandgap_select <= 1'b0;
			end else begin
				if (regWr && regAddr == MCU_CTRL_OFS) begin
					jtag_disable_bit <= regWdata[JTAG_DIS_BIT];
				end
				if (regWr && regAddr == CMP_CTRL_OFS) begin
					comparator_bandgap_select <= regWdata[CMP_BG_BIT];
				end
			end
		end
	end

	// gates drive the peripheral clock enables; freezing keeps peripheral state
	assign lcd_gate = clock_gate_reg[LCD_BIT];
	assign timer1_gate = clock_gate_reg[TIMER1_BIT];
	assign spi_gate = clock_gate_reg[SPI_BIT];
	assign usart_gate = clock_gate_reg[USART_BIT];
	assign adc_gate = clock_gate_reg[ADC_BIT];
	assign cmpMuxAllowed = ~clock_gate_reg[ADC_BIT];

	// bandgap reference on only when someone needs it; software waits start-up
	assign bandgapEn = brownoutEnabled | comparator_bandgap_select | adcEnabled;

	// jtag enable and tdo driver
	assign jtagEnabled = jtagFuseProg & ~jtag_disable_bit;
	assign tdoOe = jtagEnabled & tapShifting;
	assign tdoOut = tdoData & tdoOe;

	// reserved codes turn the sleep instruction into a no-op
	always_comb begin
		case (sleep_mode_select)
			MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE: modeValid = 1'b1;
			MODE_STANDBY: modeValid = extCrystalSel;
			default: modeValid = 1'b0;
		endcase
	end

	// wake conditions per mode; power-down and standby accept only asynchronous sources
	always_comb begin
		case (activeMode)
			MODE_PDOWN, MODE_STANDBY: wakeEvent = wakeSerialStart | wakeExtLevel0 | wakePinChange;
			MODE_PSAVE: wakeEvent = wakeSerialStart | wakeExtLevel0 | wakePinChange | wakeIntAny;
			default: wakeEvent = wakeIntAny | wakeSerialStart | wakeExtLevel0 | wakePinChange;
		endcase
	end

	// next state of the sleep sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (sleepInstr && sleep_enable && modeValid) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wakeEvent) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (wakeCnt == 3'h1) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_RUN;
		endcase
	end

	// sequencer state; resets abort sleep
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RUN;
		end else if (clkEn) begin
			if (internalReset) begin
				state <= ST_RUN;
			end else begin
				state <= next_state;
			end
		end
	end

	// latched mode and wake latency counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			activeMode <= MODE_IDLE;
			wakeCnt <= 3'h0;
		end else if (clkEn) begin
			if (state == ST_RUN && next_state == ST_SLEEP) begin
				activeMode <= sleep_mode_select;
			end
			if (state == ST_SLEEP && next_state == ST_WAKE) begin
				// other modes reuse the same count as a simplification
				wakeCnt <= STANDBY_WAKE_CYC;
			end else if (wakeCnt != 3'h0) begin
				wakeCnt <= wakeCnt - 3'h1;
			end
		end
	end

	assign sleeping = (state == ST_SLEEP);

	// read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 8'h00;
		end else if (clkEn) begin
			regRdata <= 8'h00;
			if (regRd) begin
				case (regAddr)
					SLEEP_CTRL_OFS: regRdata <= {4'h0, sleep_mode_select, sleep_enable};
					GATE_OFS: regRdata <= {3'h0, clock_gate_reg};
					MCU_CTRL_OFS: regRdata <= {jtag_disable_bit, 7'h00};
					CMP_CTRL_OFS: regRdata <= {1'b0, comparator_bandgap_select, 6'h00};
					STATUS_OFS: regRdata <= {3'h0, bandgapEn, jtagEnabled, activeMode == MODE_STANDBY,
						sleeping, internalReset};
					default: regRdata <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== sgrc_ctrl_properties.sv
// Purpose: port level assertions for the sleep, gating and reset block
// Assumes: one clock domain, rst_n asynchronous active low
// Notes: bound from the testbench top file, sees top ports only
`timescale 1ns/10ps
`default_nettype none
module sgrc_ctrl_properties
	import sgrc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	// sleep handshake
	input wire logic sleepInstr,
	input wire logic sleeping,
	input wire logic [2:0] activeMode,
	// reset sources and fuses
	input wire logic powerLow,
	input wire logic resetPin_n,
	input wire logic jtagResetReg,
	input wire logic [1:0] brownout_level_fuses,
	input wire logic jtagFuseProg,
	// analog and jtag inputs, analog, jtag and reset outputs
	input wire logic adcEnabled,
	input wire logic tapShifting,
	input wire logic adc_gate,
	input wire logic cmpMuxAllowed,
	input wire logic bandgapEn,
	input wire logic jtagEnabled,
	input wire logic tdoOe,
	input wire logic ioPortReset,
	input wire logic internalReset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// reset must outlive the synchroniser after the last source drops
	sequence s_held;
		internalReset [*3];
	endsequence
	property p_rsv; regRd && regAddr == GATE_OFS |=> regRdata[7:5] == 3'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("gate reserved bits nonzero");
	property p_mux; cmpMuxAllowed == !adc_gate; endproperty
	a_mux: assert property (p_mux) else $error("comparator mux open with adc gated");
	property p_bg; brownout_level_fuses != 2'h3 || adcEnabled |-> bandgapEn; endproperty
	a_bg: assert property (p_bg) else $error("bandgap off while needed");
	property p_io; powerLow || !resetPin_n || jtagResetReg |-> ioPortReset; endproperty
	a_io: assert property (p_io) else $error("port reset missing");
	property p_int; ioPortReset |-> internalReset; endproperty
	a_int: assert property (p_int) else $error("internal reset missing");
	property p_str; $fell(ioPortReset) |-> s_held; endproperty
	a_str: assert property (p_str) else $error("reset not stretched");
	property p_tdo; tdoOe |-> jtagEnabled && tapShifting; endproperty
	a_tdo: assert property (p_tdo) else $error("tdo driven while idle");
	property p_jtf; !jtagFuseProg |-> !jtagEnabled; endproperty
	a_jtf: assert property (p_jtf) else $error("jtag on with fuse open");
	property p_se; $rose(sleeping) |-> $past(sleepInstr); endproperty
	a_se: assert property (p_se) else $error("sleep without instruction");
	property p_mode; sleeping |-> !(activeMode inside {3'h4, 3'h5, 3'h7}); endproperty
	a_mode: assert property (p_mode) else $error("sleeping in reserved mode");
endmodule
`default_nettype wire

// ===== sgrc_core_model.sv
// Purpose: core side model driving the register port and sleep instruction
// Assumes: register port answers one cycle after a read strobe
// Notes: strobes change only by non-blocking assignment after a rising edge
`timescale 1ns/10ps
`default_nettype none
module sgrc_core_model
	import sgrc_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	output logic regWr,
	output logic regRd,
	input wire logic [7:0] regRdata,
	// sleep handshake
	output logic sleepInstr,
	output logic extCrystalSel
);
	// idle values from time zero
	initial begin
		{regAddr, regWdata, regWr, regRd, sleepInstr, extCrystalSel} = '0;
	end
	// one cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// data is taken at the edge closing the answer cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		d = regRdata;
	endtask
	// enable is set just before the instruction
	task automatic sleep(input logic [2:0] m, input logic se);
		extCrystalSel <= (m == MODE_STANDBY);
		wr(SLEEP_CTRL_OFS, {4'h0, m, se});
		sleepInstr <= 1'b1;
		@(posedge clk);
		sleepInstr <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the sleep, gating and reset block
// Assumes: 200 MHz clock, clkEn high except during the lost-write check
// Notes: short fuse delay chosen so the stretch is sixteen cycles
`timescale 1ns/10ps
`default_nettype none
module tb
	import sgrc_pkg::*;
;
	// clock, reset and port signals
	logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
	logic [7:0] regAddr, regWdata, regRdata;
	logic regWr, regRd, sleepInstr, extCrystalSel, sleeping, coreRun;
	logic [2:0] activeMode;
	logic wakeIntAny = 0, wakeSerialStart = 0, wakeExtLevel0 = 0, wakePinChange = 0;
	logic powerLow = 0, resetPin_n = 1, watchdogPulse = 0, brownoutLow = 0, jtagResetReg = 0;
	logic [1:0] startup_time_fuses = 2'h1, brownout_level_fuses = 2'h3;
	logic [3:0] clock_select_fuses = 4'h0;
	logic jtagFuseProg = 1, adcEnabled = 0, tapShifting = 0, tdoData = 0;
	logic lcd_gate, timer1_gate, spi_gate, usart_gate, adc_gate, cmpMuxAllowed, bandgapEn;
	logic jtagEnabled, tdoOut, tdoOe, ioPortReset, internalReset;
	int n_mismatch = 0, checks = 0;
	sgrc_ctrl i_sgrc_ctrl (.*);
	sgrc_core_model i_sgrc_core_model (.*);
	// free running clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// cycles until the internal reset drops, bounded
	task automatic waitRst(output int n);
		n = 0;
		while (internalReset !== 1'b0 && n < 6000) begin
			@(posedge clk);
			n++;
		end
	endtask
	// verdict
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// reset values, reserved bits, gate outputs, unmapped address
	task automatic t_regs();
		logic [7:0] d;
		i_sgrc_core_model.rd(SLEEP_CTRL_OFS, d);
		chk(d, SLEEP_CTRL_RST);
		// status after reset: only the jtag enable is up
		i_sgrc_core_model.rd(STATUS_OFS, d);
		chk(d, 8'h08);
		i_sgrc_core_model.rd(GATE_OFS, d);
		chk(d, {3'h0, GATE_RST});
		i_sgrc_core_model.wr(GATE_OFS, 8'hff);
		i_sgrc_core_model.rd(GATE_OFS, d);
		chk(d, 8'h1f);
		chk({lcd_gate, timer1_gate, spi_gate, usart_gate, adc_gate, cmpMuxAllowed}, 8'h3e);
		i_sgrc_core_model.wr(GATE_OFS, 8'h0a);
		@(negedge clk);
		chk({lcd_gate, timer1_gate, spi_gate, usart_gate, adc_gate, cmpMuxAllowed}, 8'h15);
		i_sgrc_core_model.rd(8'h10, d);
		chk(d, 8'h00);
		i_sgrc_core_model.wr(GATE_OFS, 8'h00);
		// a write while the clock enable is low must be lost
		clkEn <= 1'b0;
		i_sgrc_core_model.wr(GATE_OFS, 8'h01);
		clkEn <= 1'b1;
		@(negedge clk);
		chk(adc_gate, 1'b0);
	endtask
	// every mode code, wake latency, power-down ignoring plain interrupts
	task automatic t_sleep();
		int n;
		for (int m = 0; m < 8; m++) begin
			i_sgrc_core_model.sleep(m[2:0], 1'b1);
			@(negedge clk);
			chk(sleeping, (m < 4) || (m == 6));
			if (m == 2) begin
				@(posedge clk);
				wakeIntAny <= 1'b1;
				@(posedge clk);
				wakeIntAny <= 1'b0;
				@(negedge clk);
				chk(sleeping, 1'b1);
			end
			if ((m < 4) || (m == 6)) begin
				@(posedge clk);
				wakePinChange <= 1'b1;
				@(posedge clk);
				wakePinChange <= 1'b0;
				n = 0;
				while (coreRun !== 1'b1 && n < 20) begin
					@(posedge clk);
					n++;
				end
				chk(n >= 4 && n <= 8, 1'b1);
			end
			i_sgrc_core_model.wr(SLEEP_CTRL_OFS, 8'h00);
		end
		i_sgrc_core_model.sleep(MODE_IDLE, 1'b0);
		@(negedge clk);
		chk(sleeping, 1'b0);
	endtask
	// bandgap sources and jtag enable with tdo drive
	task automatic t_analog();
		chk(bandgapEn, 1'b0);
		@(posedge clk);
		adcEnabled <= 1'b1; // no reference result is used by the bench
		@(negedge clk);
		chk(bandgapEn, 1'b1);
		@(posedge clk);
		adcEnabled <= 1'b0;
		i_sgrc_core_model.wr(CMP_CTRL_OFS, 8'h40);
		@(negedge clk);
		chk(bandgapEn, 1'b1);
		i_sgrc_core_model.wr(CMP_CTRL_OFS, 8'h00);
		@(negedge clk);
		chk({bandgapEn, jtagEnabled, tdoOe}, 8'h02);
		@(posedge clk);
		tapShifting <= 1'b1;
		tdoData <= 1'b1;
		@(negedge clk);
		chk({jtagEnabled, tdoOe, tdoOut}, 8'h07);
		i_sgrc_core_model.wr(MCU_CTRL_OFS, 8'h80);
		@(negedge clk);
		chk({jtagEnabled, tdoOe}, 8'h00);
		i_sgrc_core_model.wr(MCU_CTRL_OFS, 8'h00);
		jtagFuseProg <= 1'b0;
		@(negedge clk);
		chk(jtagEnabled, 1'b0);
	endtask
	// each source in turn, registers cleared, stretch length
	task automatic t_reset();
		int n;
		logic [7:0] d;
		brownout_level_fuses <= 2'h0;
		i_sgrc_core_model.wr(GATE_OFS, 8'h1f);
		for (int s = 0; s < 5; s++) begin
			@(posedge clk);
			case (s)
				0: powerLow <= 1'b1;
				1: resetPin_n <= 1'b0;
				2: watchdogPulse <= 1'b1;
				3: brownoutLow <= 1'b1;
				default: jtagResetReg <= 1'b1;
			endcase
			@(negedge clk);
			chk({bandgapEn, internalReset}, 8'h03);
			@(posedge clk);
			{powerLow, watchdogPulse, brownoutLow, jtagResetReg} <= 4'h0;
			resetPin_n <= 1'b1;
			waitRst(n);
			chk(n >= 16 && n <= 24, 1'b1);
		end
		// shortest fuse delay after a watchdog pulse
		startup_time_fuses <= 2'h0;
		@(posedge clk);
		watchdogPulse <= 1'b1;
		@(posedge clk);
		watchdogPulse <= 1'b0;
		waitRst(n);
		chk(n[7:0], DELAY_MIN[7:0] + 8'h01);
		i_sgrc_core_model.rd(GATE_OFS, d);
		chk(d, 8'h00);
	endtask
	// main sequence
	initial begin
		int n;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		waitRst(n);
		chk(n >= 16 && n <= 24, 1'b1);
		t_regs();
		t_sleep();
		t_analog();
		t_reset();
		results();
	end
	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		results();
	end
endmodule
bind sgrc_ctrl sgrc_ctrl_properties i_sgrc_ctrl_properties (.*);
`default_nettype wire
